// ==== hdsc_defs.vh ====
// Constants for the halt debug state control block
`ifndef HDSC_DEFS_VH
`define HDSC_DEFS_VH
`define HDSC_MODE_USR 5'h10
`define HDSC_MODE_MON 5'h16
`define HDSC_WATCHPOINT_FAULT_ADDRESS_REGISTER_ARM_OFS 32'h00000008
`define HDSC_WATCHPOINT_FAULT_ADDRESS_REGISTER_NARROW_OFS 32'h00000004
`define HDSC_METHOD_W 4
`define HDSC_METHOD_RST 4'h0
`define HDSC_CLS_OTHER 3'h0
`define HDSC_CLS_DBGCP 3'h1
`define HDSC_CLS_BANKED 3'h2
`define HDSC_CLS_RESTR 3'h3
`define HDSC_CLS_CONFIG 3'h4
`define HDSC_CLS_SCRWR 3'h5
`define HDSC_CLS_PRIV 3'h6
`define HDSC_ST_RUN 3'h0
`define HDSC_ST_HALT 3'h1
`define HDSC_ST_EXIT 3'h2
`define HDSC_ST_DROP 3'h3
`define HDSC_ST_RESUME 3'h4
`endif

// ==== hdsc_sync.v ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module hdsc_sync #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1;

    always @(posedge clk) begin
        if (rst) begin
            stage1 <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// ==== hdsc_halt_ctrl.v ====
// Halt debug state control: access checks, halted exceptions, restart
`timescale 1ns/100ps
`include "hdsc_defs.vh"
module hdsc_halt_ctrl #(
    parameter AW = 32
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Debug enable pins
    input wire invasive_debug_enable,
    input wire secure_invasive_debug_enable,
    // Core context
    input wire [4:0] current_mode,
    input wire nonsecure_bit,
    input wire narrow_isa_state,
    input wire abort_mask,
    // Debug entry
    input wire entry_req,
    input wire [`HDSC_METHOD_W-1:0] entry_method,
    input wire entry_is_watchpoint,
    input wire [AW-1:0] watch_instr_addr,
    input wire entry_barrier_abort,
    input wire [1:0] entry_barrier_abort_type,
    // Debugger instruction issue
    input wire instr_valid,
    input wire [2:0] instr_class,
    input wire config_access_ok,
    input wire other_cp_allowed,
    // Exceptions while halted
    input wire undef_event,
    input wire precise_abort,
    input wire [AW-1:0] precise_abort_addr,
    input wire [7:0] precise_abort_status,
    input wire imprecise_abort,
    input wire debug_event,
    input wire supervisor_call,
    input wire secure_monitor_call,
    // Restart and status control
    input wire restart_req,
    input wire cross_trigger_restart,
    input wire force_ack,
    input wire sticky_clear,
    // Instruction verdict
    output reg instr_exec,
    output reg instr_undef,
    output reg instr_use_nonsecure,
    // Status bits
    output reg core_halted,
    output reg core_restarted,
    output reg sticky_undef,
    output reg sticky_precise_abort,
    output reg sticky_imprecise_abort,
    output reg [`HDSC_METHOD_W-1:0] entry_method_field,
    output reg debug_acknowledge,
    // Fault registers
    output reg [AW-1:0] watchpoint_fault_address_register,
    output reg [AW-1:0] fault_address_register,
    output reg [7:0] data_fault_status_register,
    output reg fault_write,
    // Recorded abort after exit
    output reg abort_pending,
    output reg [1:0] abort_pending_type,
    output reg abort_take,
    // Noninvasive freeze and exception handling
    output reg observe_enable,
    output reg exception_enable,
    output reg resume_pulse
);
    wire [1:0] pins;
    wire dbg_en;
    wire sdbg_en;
    reg [2:0] state;
    reg [2:0] next_state;
    reg halted;
    reg ok;
    reg undef;
    reg use_ns;
    wire is_user;
    wire is_mon;
    wire secure;
    wire both_en;
    wire priv_mode_ok;
    wire go;
    wire in_run;
    wire enter_now;

    hdsc_sync #(.WIDTH(2)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({invasive_debug_enable, secure_invasive_debug_enable}),
        .dout(pins)
    );
    assign dbg_en = pins[1];
    assign sdbg_en = pins[0];

    assign is_user = (current_mode == `HDSC_MODE_USR);
    assign is_mon = (current_mode == `HDSC_MODE_MON);
    // Monitor counts as secure whatever the nonsecure bit says
    assign secure = !nonsecure_bit || is_mon;
    assign both_en = dbg_en && sdbg_en;
    // Permission to move the mode field to a privileged mode
    assign priv_mode_ok = !is_user || both_en || !secure;
    assign go = restart_req || cross_trigger_restart;
    assign in_run = (state == `HDSC_ST_RUN);
    assign enter_now = in_run && entry_req;

    // Access decoding for debugger-issued instructions
    always @* begin
        ok = 1'b0;
        use_ns = 1'b0;
        case (instr_class)
            `HDSC_CLS_DBGCP: begin
                ok = 1'b1;
            end
            `HDSC_CLS_OTHER: begin
                ok = other_cp_allowed;
            end
            `HDSC_CLS_SCRWR: begin
                // Nonsecure non-Monitor never writes it
                ok = secure && (!is_user || both_en);
            end
            `HDSC_CLS_PRIV: begin
                ok = priv_mode_ok;
            end
            `HDSC_CLS_BANKED: begin
                if (secure) begin
                    ok = !is_user || both_en;
                    use_ns = nonsecure_bit && is_mon;
                end else begin
                    ok = 1'b1;
                    use_ns = 1'b1;
                end
            end
            `HDSC_CLS_RESTR: begin
                // Secure privilege is never granted in nonsecure state
                ok = secure && (!is_user || both_en);
            end
            `HDSC_CLS_CONFIG: begin
                if (secure) begin
                    ok = !is_user || both_en;
                end else begin
                    ok = config_access_ok;
                end
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        undef = instr_valid && halted && !ok;
    end

    // Restart sequencer
    always @* begin
        next_state = state;
        case (state)
            `HDSC_ST_RUN: begin
                if (entry_req) begin
                    next_state = `HDSC_ST_HALT;
                end
            end
            `HDSC_ST_HALT: begin
                if (go) begin
                    next_state = `HDSC_ST_EXIT;
                end
            end
            `HDSC_ST_EXIT: begin
                next_state = `HDSC_ST_DROP;
            end
            `HDSC_ST_DROP: begin
                next_state = `HDSC_ST_RESUME;
            end
            `HDSC_ST_RESUME: begin
                next_state = `HDSC_ST_RUN;
            end
            default: begin
                next_state = `HDSC_ST_RUN;
            end
        endcase
    end

    // Restart sequencer and halt status
    always @(posedge clk) begin
        // System reset leaves debug state like any reset
        if (rst) begin
            state <= `HDSC_ST_RUN;
            halted <= 1'b0;
            core_halted <= 1'b0;
            core_restarted <= 1'b1;
            resume_pulse <= 1'b0;
        end else begin
            state <= next_state;
            resume_pulse <= 1'b0;
            case (state)
                `HDSC_ST_RUN: begin
                    // Debug events, supervisor and monitor calls ignored
                    // in every state, not only while halted
                    if (entry_req) begin
                        halted <= 1'b1;
                        core_halted <= 1'b1;
                    end
                end
                `HDSC_ST_HALT: begin
                    if (go) begin
                        core_restarted <= 1'b0;
                    end
                end
                `HDSC_ST_EXIT: begin
                    halted <= 1'b0;
                end
                `HDSC_ST_DROP: begin
                    core_halted <= 1'b0;
                end
                `HDSC_ST_RESUME: begin
                    resume_pulse <= 1'b1;
                    core_restarted <= 1'b1;
                end
                default: begin
                    halted <= 1'b0;
                end
            endcase
        end
    end

    // Acknowledge: high in debug state or while forced
    always @(posedge clk) begin
        if (rst) begin
            debug_acknowledge <= 1'b0;
        end else if (force_ack) begin
            debug_acknowledge <= 1'b1;
        end else if (enter_now) begin
            debug_acknowledge <= 1'b1;
        end else if (in_run || state == `HDSC_ST_DROP) begin
            debug_acknowledge <= 1'b0;
        end
    end

    // Observation and exception vectoring frozen while halted
    always @(posedge clk) begin
        if (rst) begin
            observe_enable <= 1'b1;
            exception_enable <= 1'b1;
        end else if (enter_now) begin
            observe_enable <= 1'b0;
            exception_enable <= 1'b0;
        end else if (state == `HDSC_ST_DROP) begin
            observe_enable <= 1'b1;
            exception_enable <= 1'b1;
        end
    end

    // Entry cause loaded once per entry, watchpoint address once per watchpoint entry
    always @(posedge clk) begin
        if (rst) begin
            entry_method_field <= `HDSC_METHOD_RST;
            watchpoint_fault_address_register <= {AW{1'b0}};
        end else if (enter_now) begin
            entry_method_field <= entry_method;
            if (entry_is_watchpoint) begin
                if (narrow_isa_state) begin
                    watchpoint_fault_address_register <=
                        watch_instr_addr + `HDSC_WATCHPOINT_FAULT_ADDRESS_REGISTER_NARROW_OFS;
                end else begin
                    watchpoint_fault_address_register <=
                        watch_instr_addr + `HDSC_WATCHPOINT_FAULT_ADDRESS_REGISTER_ARM_OFS;
                end
            end
        end
    end

    // Application abort recorded at entry, acted on after exit
    always @(posedge clk) begin
        if (rst) begin
            abort_pending <= 1'b0;
            abort_pending_type <= 2'h0;
            abort_take <= 1'b0;
        end else begin
            abort_take <= 1'b0;
            if (enter_now) begin
                // Same-access imprecise abort is held for later
                if (entry_barrier_abort ||
                        (entry_is_watchpoint && imprecise_abort)) begin
                    abort_pending <= 1'b1;
                    abort_pending_type <= entry_barrier_abort_type;
                end
            end else if (in_run && abort_pending && !abort_mask) begin
                abort_take <= 1'b1;
                abort_pending <= 1'b0;
            end
        end
    end

    // Registered verdict for each debugger instruction
    always @(posedge clk) begin
        if (rst) begin
            instr_exec <= 1'b0;
            instr_undef <= 1'b0;
            instr_use_nonsecure <= 1'b0;
        end else begin
            instr_exec <= instr_valid && halted && ok;
            instr_undef <= undef;
            instr_use_nonsecure <= use_ns;
        end
    end

    // Sticky flags: software clear, any set in the same cycle wins
    always @(posedge clk) begin
        if (rst) begin
            sticky_undef <= 1'b0;
            sticky_precise_abort <= 1'b0;
            sticky_imprecise_abort <= 1'b0;
        end else begin
            if (sticky_clear) begin
                sticky_undef <= 1'b0;
                sticky_precise_abort <= 1'b0;
                sticky_imprecise_abort <= 1'b0;
            end
            if (halted && (undef || undef_event)) begin
                sticky_undef <= 1'b1;
            end
            if (halted && precise_abort) begin
                sticky_precise_abort <= 1'b1;
            end
            if (halted && imprecise_abort) begin
                // Discarded; recorded application abort kept
                sticky_imprecise_abort <= 1'b1;
            end
        end
    end

    // Fault registers follow a precise abort as in normal state
    always @(posedge clk) begin
        if (rst) begin
            fault_address_register <= {AW{1'b0}};
            data_fault_status_register <= 8'h00;
            fault_write <= 1'b0;
        end else begin
            fault_write <= 1'b0;
            if (halted && precise_abort) begin
                fault_address_register <= precise_abort_addr;
                data_fault_status_register <= precise_abort_status;
                fault_write <= 1'b1;
            end
        end
    end
endmodule

// ==== hdsc_halt_ctrl_asserts.sv ====
// Port checker for the halt debug state control block
`timescale 1ns/100ps
`include "hdsc_defs.vh"
module hdsc_halt_ctrl_asserts #(
    parameter AW = 32
) (
    // Clock, reset and context
    input wire clk, rst, nonsecure_bit, narrow_isa_state, force_ack,
    input wire [4:0] current_mode,
    // Requests
    input wire instr_valid, entry_is_watchpoint, precise_abort,
    input wire imprecise_abort, restart_req, cross_trigger_restart,
    input wire [2:0] instr_class,
    input wire [AW-1:0] watch_instr_addr, precise_abort_addr,
    // Status and verdict
    input wire instr_exec, instr_undef, instr_use_nonsecure, core_halted,
    input wire core_restarted, sticky_undef, sticky_precise_abort,
    input wire sticky_imprecise_abort, debug_acknowledge, fault_write,
    input wire abort_pending, observe_enable, exception_enable, resume_pulse,
    input wire [AW-1:0] watchpoint_fault_address_register,
    input wire [AW-1:0] fault_address_register,
    input wire [7:0] data_fault_status_register
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Steady halt: not in the middle of an exit
    wire halt = core_halted && core_restarted;
    wire iss = instr_valid && halt;
    wire mon = current_mode == `HDSC_MODE_MON;
    wire nsx = nonsecure_bit && !mon;

    property p_scr; iss && instr_class == `HDSC_CLS_SCRWR && nsx
        |=> instr_undef && !instr_exec; endproperty
    a_scr: assert property (p_scr) else $error("config write ran");
    property p_dbgcp; iss && instr_class == `HDSC_CLS_DBGCP
        |=> instr_exec && !instr_undef; endproperty
    a_dbgcp: assert property (p_dbgcp) else $error("debug cp refused");
    property p_restr; iss && instr_class == `HDSC_CLS_RESTR && nsx
        |=> instr_undef; endproperty
    a_restr: assert property (p_restr) else $error("restricted ran");
    property p_priv; iss && !nonsecure_bit && instr_class == `HDSC_CLS_BANKED
        && current_mode != `HDSC_MODE_USR
        |=> instr_exec && !instr_use_nonsecure; endproperty
    a_priv: assert property (p_priv) else $error("secure banked bad");
    property p_sticky; instr_undef |-> sticky_undef; endproperty
    a_sticky: assert property (p_sticky) else $error("sticky not set");
    property p_freeze; core_halted |-> !observe_enable && !exception_enable;
    endproperty
    a_freeze: assert property (p_freeze) else $error("not frozen");
    property p_ack; $rose(core_halted) |-> debug_acknowledge; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_watchpoint_fault_address_register; $rose(core_halted) && $past(entry_is_watchpoint)
        |-> watchpoint_fault_address_register == $past(watch_instr_addr)
        + ($past(narrow_isa_state) ? 4 : 8); endproperty
    a_watchpoint_fault_address_register: assert property (p_watchpoint_fault_address_register) else $error("watchpoint_fault_address_register wrong");
    property p_prec; halt && precise_abort |=> sticky_precise_abort
        && core_halted && fault_address_register == $past(precise_abort_addr);
    endproperty
    a_prec: assert property (p_prec) else $error("precise abort bad");
    property p_impr; halt && imprecise_abort |=> sticky_imprecise_abort
        && !fault_write && $stable(data_fault_status_register)
        && $stable(abort_pending); endproperty
    a_impr: assert property (p_impr) else $error("imprecise bad");
    property p_rst; disable iff (1'b0) rst
        |=> !core_halted && !debug_acknowledge && core_restarted; endproperty
    a_rst: assert property (p_rst) else $error("reset kept halt");
    property p_exit; halt && (restart_req || cross_trigger_restart)
        |=> !core_restarted && core_halted ##2 !core_halted && !core_restarted
        && debug_acknowledge == force_ack ##1 resume_pulse && core_restarted;
    endproperty
    a_exit: assert property (p_exit) else $error("exit order bad");
    c_entry: cover property ($rose(core_halted));
    c_exit: cover property ($rose(resume_pulse));
    c_undef: cover property (instr_undef);
endmodule

// ==== hdsc_dbg_model.sv ====
// Debugger and trigger model: issues instructions and restart requests
`timescale 1ns/100ps
module hdsc_dbg_model (
    // Clock
    input wire clk,
    // Requests to the core
    output reg instr_valid,
    output reg [2:0] instr_class,
    output reg restart_req,
    output reg cross_trigger_restart,
    // Verdict
    input wire instr_exec,
    input wire instr_undef,
    input wire instr_use_nonsecure
);
    initial begin
        {instr_valid, instr_class, restart_req, cross_trigger_restart} = 6'h0;
    end
    // One instruction; the verdict is registered one cycle after the issue
    task issue(input [2:0] cls, output [2:0] v);
        begin
            @(posedge clk);
            #1;
            instr_valid = 1'b1;
            instr_class = cls;
            @(posedge clk);
            #1;
            instr_valid = 1'b0;
            instr_class = ~cls;
            v = {instr_exec, instr_undef, instr_use_nonsecure};
        end
    endtask
    task restart(input ct);
        reg [2:0] v;
        begin
            issue(3'h0, v);
            @(posedge clk);
            #1;
            restart_req = !ct;
            cross_trigger_restart = ct;
            @(posedge clk);
            #1;
            restart_req = 1'b0;
            cross_trigger_restart = 1'b0;
        end
    endtask
endmodule

// ==== tb_hdsc_halt_ctrl.sv ====
// Testbench for the halt debug state control block
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_hdsc_halt_ctrl;
    // Any privileged mode other than Monitor
    localparam [4:0] prv = 5'h1f;
    localparam [4:0] usr = 5'h10;
    localparam [4:0] mon = 5'h16;
    reg clk, rst, invasive_debug_enable, secure_invasive_debug_enable;
    reg nonsecure_bit, narrow_isa_state, abort_mask, entry_req, took;
    reg entry_is_watchpoint, entry_barrier_abort, config_access_ok;
    reg other_cp_allowed, undef_event, precise_abort, imprecise_abort;
    reg debug_event, supervisor_call, secure_monitor_call, force_ack;
    reg sticky_clear;
    reg [4:0] current_mode;
    reg [3:0] entry_method;
    reg [31:0] watch_instr_addr, precise_abort_addr;
    reg [1:0] entry_barrier_abort_type;
    reg [7:0] precise_abort_status;
    wire instr_valid, restart_req, cross_trigger_restart, instr_exec;
    wire instr_undef, instr_use_nonsecure, core_halted, core_restarted;
    wire sticky_undef, sticky_precise_abort, sticky_imprecise_abort;
    wire debug_acknowledge, fault_write, abort_pending, abort_take;
    wire observe_enable, exception_enable, resume_pulse;
    wire [2:0] instr_class;
    wire [3:0] entry_method_field;
    wire [31:0] watchpoint_fault_address_register, fault_address_register;
    wire [1:0] abort_pending_type;
    wire [7:0] data_fault_status_register;
    integer err_total = 0;
    integer compares = 0;
    integer cyc = 0;

    hdsc_halt_ctrl i_hdsc_halt_ctrl (.*);
    hdsc_dbg_model i_hdsc_dbg_model (.*);

    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            test_done;
        end
    end
    task test_done;
        begin
            $display("errors %0d compares %0d", err_total, compares);
            if (err_total == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task step(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task enter(input [3:0] m, input [31:0] a, input nar, input ba);
        reg [31:0] w;
        begin
            w = a + (nar ? 32'h4 : 32'h8);
            {entry_method, watch_instr_addr} = {m, a};
            {narrow_isa_state, entry_barrier_abort} = {nar, ba};
            entry_req = 1'b1;
            step(1);
            entry_req = 1'b0;
            `CHK("ack", 1'b1, debug_acknowledge)
            `CHK("method", m, entry_method_field)
            `CHK("watchpoint_fault_address_register", w, watchpoint_fault_address_register)
            `CHK("observe", 1'b0, observe_enable)
        end
    endtask
    task row(input [4:0] md, input ns, en, ok, input [2:0] cls, e);
        reg [2:0] v;
        begin
            {current_mode, nonsecure_bit} = {md, ns};
            {invasive_debug_enable, secure_invasive_debug_enable} = {en, en};
            {config_access_ok, other_cp_allowed} = {ok, ok};
            step(3);
            i_hdsc_dbg_model.issue(cls, v);
            `CHK("verdict", e[2:1], v[2:1])
            if (cls == 3'h2)
                `CHK("nonsecure", e[0], v[0])
        end
    endtask
    task ev(input [5:0] s);
        begin
            {undef_event, precise_abort, imprecise_abort, debug_event,
                supervisor_call, secure_monitor_call} = s;
            step(1);
            {undef_event, precise_abort, imprecise_abort, debug_event,
                supervisor_call, secure_monitor_call} = 6'h0;
        end
    endtask

    initial begin
        {clk, invasive_debug_enable, secure_invasive_debug_enable, took,
            nonsecure_bit, narrow_isa_state, entry_req, entry_is_watchpoint,
            entry_barrier_abort, config_access_ok, other_cp_allowed,
            undef_event, precise_abort, imprecise_abort, debug_event,
            supervisor_call, secure_monitor_call, force_ack, sticky_clear,
            current_mode, entry_method, watch_instr_addr} = 0;
        {precise_abort_addr, precise_abort_status} = {32'h2468, 8'h5a};
        {rst, abort_mask, entry_barrier_abort_type} = {2'b11, 2'h2};
        step(8);
        rst = 1'b0;
        entry_is_watchpoint = 1'b1;
        enter(4'h4, 32'h1000, 1'b0, 1'b0);
        row(usr, 0, 0, 1, 3'h1, 3'b100);
        row(usr, 0, 0, 1, 3'h2, 3'b010);
        row(usr, 0, 0, 1, 3'h6, 3'b010);
        row(usr, 0, 1, 1, 3'h5, 3'b100);
        row(usr, 1, 1, 1, 3'h5, 3'b010);
        row(mon, 1, 0, 1, 3'h5, 3'b100);
        row(mon, 1, 0, 1, 3'h2, 3'b101);
        row(prv, 0, 0, 1, 3'h2, 3'b100);
        row(prv, 1, 1, 1, 3'h2, 3'b101);
        row(prv, 1, 1, 1, 3'h3, 3'b010);
        row(prv, 1, 0, 0, 3'h4, 3'b010);
        row(usr, 1, 0, 1, 3'h4, 3'b100);
        row(usr, 1, 0, 1, 3'h6, 3'b100);
        row(prv, 0, 0, 0, 3'h0, 3'b010);
        row(prv, 0, 0, 1, 3'h0, 3'b100);
        `CHK("sticky_undef", 1'b1, sticky_undef)
        sticky_clear = 1'b1;
        step(1);
        sticky_clear = 1'b0;
        `CHK("sticky_clr", 1'b0, sticky_undef)
        ev(6'h20);
        `CHK("sticky_undef", 1'b1, sticky_undef)
        ev(6'h10);
        `CHK("far", 32'h2468, fault_address_register)
        `CHK("data_fault_status_register", 8'h5a, data_fault_status_register)
        `CHK("sticky_pre", 1'b1, sticky_precise_abort)
        ev(6'h08);
        `CHK("sticky_imp", 1'b1, sticky_imprecise_abort)
        `CHK("data_fault_status_register", 8'h5a, data_fault_status_register)
        ev(6'h07);
        `CHK("method", 4'h4, entry_method_field)
        `CHK("excen", 1'b0, exception_enable)
        i_hdsc_dbg_model.restart(1'b0);
        step(3);
        `CHK("state", 5'b01011, {core_halted, core_restarted,
            debug_acknowledge, observe_enable, resume_pulse})
        `CHK("pending", 1'b0, abort_pending)
        enter(4'ha, 32'h3000, 1'b1, 1'b1);
        force_ack = 1'b1;
        i_hdsc_dbg_model.restart(1'b1);
        step(4);
        `CHK("ack", 1'b1, debug_acknowledge)
        `CHK("pending", 3'b110, {abort_pending, abort_pending_type})
        abort_mask = 1'b0;
        repeat (8) begin
            step(1);
            took = took | abort_take;
        end
        `CHK("take", 1'b1, took)
        force_ack = 1'b0;
        step(1);
        `CHK("ack", 1'b0, debug_acknowledge)
        enter(4'h4, 32'h0, 1'b0, 1'b0);
        rst = 1'b1;
        step(3);
        rst = 1'b0;
        `CHK("halted", 2'b00, {core_halted, debug_acknowledge})
        test_done;
    end
endmodule
bind hdsc_halt_ctrl hdsc_halt_ctrl_asserts #(.AW(AW)) i_hdsc_halt_ctrl_asserts (.*);
